// ---- rtl/mcap_pkg.sv ----
package mcap_pkg;

   // System clock and codec bit timing.
   localparam int CLK_HZ         = 100_000_000;
   localparam int CODEC_RATE_HZ  = 64_000;
   localparam int CODEC_HALF_CYC = CLK_HZ / (2 * CODEC_RATE_HZ);
   localparam int CODEC_HALF_W   = 10;

   // Codec FIFO geometry and interrupt spacing in bytes.
   localparam int CODEC_DEPTH     = 16;
   localparam int CODEC_WIDTH     = 8;
   localparam int CODEC_IRQ_BYTES = 8;

   // Audio FIFO geometry, sample width and frame layout.
   localparam int AUD_TX_DEPTH  = 8;
   localparam int AUD_RX_DEPTH  = 12;
   localparam int AUD_SAMPLE_W  = 16;
   localparam int AUD_FRAME_128 = 128;
   localparam int AUD_FRAME_64  = 64;
   localparam int AUD_MCLK_FS   = 256;
   localparam int AUD_DIV_W     = 8;

   // Reset values of the audio emergency status bits.
   localparam logic AUD_UNDERFLOW_RST = 1'b1;
   localparam logic AUD_OVERFLOW_RST  = 1'b1;

   typedef struct packed {
      logic [AUD_SAMPLE_W-1:0] left;
      logic [AUD_SAMPLE_W-1:0] right;
   } mcap_sample_t;

   typedef struct packed {
      logic value;
      logic drive;
   } mcap_pin_t;

   typedef enum logic [1:0] {
      PORT_SSI   = 2'b00,
      PORT_CODEC = 2'b01,
      PORT_AUDIO = 2'b11
   } mcap_port_t;

endpackage

// ---- rtl/mcap_fifo.sv ----
`timescale 1ns/10ps
module mcap_fifo
   #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
   )
   (
   // Clock and reset
   input  wire logic             clock,
   input  wire logic             rst,
   input  wire logic             flush,
   // Fill side
   input  wire logic             wrValid,
   input  wire logic [WIDTH-1:0] wrData,
   output logic                  wrReady,
   // Drain side
   input  wire logic             rdReady,
   output logic                  rdValid,
   output logic      [WIDTH-1:0] rdData
   );

   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH + 1);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wrPtr_r;
   logic [AW-1:0]    rdPtr_r;
   logic [CW-1:0]    count_r;

   function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
      return (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'b1);
   endfunction

   wire logic pushOk = wrValid && wrReady;
   wire logic popOk  = rdReady && rdValid;

   assign wrReady = (count_r != CW'(DEPTH));
   assign rdValid = (count_r != '0);
   assign rdData  = mem[rdPtr_r];

   always_ff @(posedge clock)
   begin
      if (rst || flush)
      begin
         wrPtr_r <= '0;
         rdPtr_r <= '0;
         count_r <= '0;
      end
      else
      begin
         if (pushOk)
            wrPtr_r <= bump(wrPtr_r);
         if (popOk)
            rdPtr_r <= bump(rdPtr_r);
         count_r <= CW'(count_r + CW'(pushOk) - CW'(popOk));
      end
   end

   always_ff @(posedge clock)
   begin
      if (pushOk)
         mem[wrPtr_r] <= wrData;
   end

endmodule

// ---- rtl/mcap_port.sv ----
// Notes on behaviour
// - Codec has separate receive and transmit FIFOs, sixteen bytes each.
// - Codec clock and sync are generated here; serial rate is 64 kbit/s.
// - With interrupt enabled, pulse the codec interrupt every eight bytes.
// - First codec interrupt comes 1 ms after the first direction enable.
// - With both codec enables clear, receive reads empty, transmit not full.
// - Codec serial output is not driven while transmit enable is low.
// - Either codec enable runs sync and interrupt logic; both clear stops it.
// - Codec writes fill transmit FIFO; each byte start loads the shifter.
// - Sync is high for one bit clock, during the byte's MSB.
// - Codec transmit shifts MSB first, changing on the bit clock rising edge.
// - Codec receive samples MSB first on falling edges; bytes enter the FIFO.
// - An empty transmit FIFO sends zero; frames continue regardless.
// - Audio sends one frame per sample period, full duplex.
// - Audio bit clock is 64 or 128 times the sample rate.
// - Audio transmit FIFO holds eight samples, receive FIFO twelve.
// - Audio starts disabled with both emergency flags set; writing one clears.
// - Audio clocks come from the main or external source via a divider.
// - Only 32 bits of each audio frame carry data; the rest are zero.
// - Word clock fall starts the right sample, rise starts the left.
// - Master clock runs at 256 times the sample rate.
// - Word clock and audio output change on bit clock falling edges.
// - Audio input is latched on bit clock rising edges.
// - After reset the shared pins are left to the undriven serial port.
`timescale 1ns/10ps
module mcap_port
   import mcap_pkg::*;
   #(
   parameter int CODEC_HALF = CODEC_HALF_CYC,
   parameter int CODEC_FD   = CODEC_DEPTH,
   parameter int AUD_TX_FD  = AUD_TX_DEPTH,
   parameter int AUD_RX_FD  = AUD_RX_DEPTH
   )
   (
   // Clock and reset
   input  wire logic                 clock,
   input  wire logic                 rst,
   // Port routing
   input  wire logic                 audioPortSelect,
   input  wire logic                 audioPortEnable,
   input  wire logic                 serialPortSelect,
   // Codec control and data
   input  wire logic                 codecReceiveEnable,
   input  wire logic                 codecTransmitEnable,
   input  wire logic                 codecIrqEnable,
   input  wire logic                 codecWrValid,
   input  wire logic [7:0]           codecWrData,
   input  wire logic                 codecRdPop,
   output logic      [7:0]           codecRdData,
   output logic                      codecRxEmptyFlag,
   output logic                      codecTxFullFlag,
   output logic                      codecHalfFifoIrq,
   // Audio control
   input  wire logic                 bitclk64xSelect,
   input  wire logic                 bitclk128xSelect,
   input  wire logic                 audioClockSource,
   input  wire logic [AUD_DIV_W-1:0] audioClockDivisor,
   input  wire logic                 audioTxChanEnable,
   input  wire logic                 audioRxChanEnable,
   input  wire logic                 underflowClear,
   input  wire logic                 overflowClear,
   // Audio data and status
   input  wire logic                 audioTxValid,
   input  wire mcap_sample_t         audioTxData,
   output logic                      audioTxReady,
   input  wire logic                 audioRxPop,
   output mcap_sample_t              audioRxData,
   output logic                      audioRxValid,
   output logic                      audioUnderflow,
   output logic                      audioOverflow,
   // Shared pins
   input  wire logic                 extAudioClock,
   input  wire logic                 serialInPin,
   output mcap_pin_t                 portClkPin,
   output mcap_pin_t                 portFramePin,
   output mcap_pin_t                 portTxDataPin,
   output mcap_pin_t                 portAuxPin
   );

   logic [CODEC_HALF_W-1:0] halfCnt_r;
   logic                    codecClk_r;
   logic [2:0]              bitIdx_r;
   logic                    codecSync_r;
   logic [7:0]              codecShift_r;
   logic [7:0]              rxShift_r;
   logic [2:0]              byteCnt_r;
   logic                    rxMeta_r;
   logic                    rxSync_r;
   logic [2:0]              extSync_r;
   logic [AUD_DIV_W-1:0]    divCnt_r;
   logic [1:0]              mclkPh_r;
   logic                    mclk_r;
   logic                    bclk_r;
   logic [6:0]              frameBit_r;
   logic                    wordClk_r;
   logic                    audio_serial_out_r;
   mcap_sample_t            curSample_r;
   logic [15:0]             rxLeft_r;
   logic [15:0]             rxRight_r;
   logic [7:0]              txHeadC;
   logic [7:0]              rxHeadC;
   logic                    txValidC;
   logic                    txReadyC;
   logic                    rxValidC;
   mcap_sample_t            txHeadA;
   mcap_sample_t            rxHeadA;
   logic                    txValidA;
   logic                    txReadyA;
   logic                    rxValidA;
   logic                    rxReadyA;

   function automatic logic bclkLevel(input logic [1:0] ph, input logic slow);
      return slow ? ph[1] : ph[0];
   endfunction

   // Mixed select settings fall back to the undriven serial port.
   wire mcap_port_t portMode = mcap_port_t'((audioPortSelect && audioPortEnable) ? PORT_AUDIO :
      (!audioPortSelect && !audioPortEnable && serialPortSelect) ? PORT_CODEC : PORT_SSI);
   wire logic audioRun = (portMode == PORT_AUDIO);

   // Codec timing decode.
   wire logic codecActive = codecReceiveEnable || codecTransmitEnable;
   wire logic codecTick   = codecActive && (halfCnt_r == CODEC_HALF_W'(CODEC_HALF - 1));
   wire logic codecRise   = codecTick && !codecClk_r;
   wire logic codecFall   = codecTick && codecClk_r;
   wire logic byteWrap    = codecRise && (bitIdx_r == 3'h7);
   wire logic byteDone    = codecFall && (bitIdx_r == 3'h7);
   wire logic txPopC      = byteWrap && codecTransmitEnable && txValidC;
   wire logic rxPushC     = byteDone && codecReceiveEnable;
   wire logic [7:0] rxByte = {rxShift_r[6:0], rxSync_r};
   // An empty FIFO or a disabled transmitter loads zero.
   wire logic [7:0] nextByte = txPopC ? txHeadC : 8'h00;

   // Both codec FIFOs are cleared while the codec is idle.
   mcap_fifo #(.WIDTH(CODEC_WIDTH), .DEPTH(CODEC_FD)) codecTxFifo
   (
      .clock  (clock),
      .rst    (rst),
      .flush  (!codecActive),
      .wrValid(codecWrValid),
      .wrData (codecWrData),
      .wrReady(txReadyC),
      .rdReady(txPopC),
      .rdValid(txValidC),
      .rdData (txHeadC)
   );

   mcap_fifo #(.WIDTH(CODEC_WIDTH), .DEPTH(CODEC_FD)) codecRxFifo
   (
      .clock  (clock),
      .rst    (rst),
      .flush  (!codecActive),
      .wrValid(rxPushC),
      .wrData (rxByte),
      .wrReady(),
      .rdReady(codecRdPop),
      .rdValid(rxValidC),
      .rdData (rxHeadC)
   );

   // The shared input pin is asynchronous to the system clock.
   always_ff @(posedge clock)
   begin
      rxMeta_r  <= serialInPin;
      rxSync_r  <= rxMeta_r;
      extSync_r <= {extSync_r[1:0], extAudioClock};
   end

   // Codec bit engine; the byte counter restarts when an enable is set while both were clear.
   always_ff @(posedge clock)
   begin
      if (rst || !codecActive)
      begin
         halfCnt_r    <= '0;
         codecClk_r   <= 1'b0;
         bitIdx_r     <= 3'h7;
         codecSync_r  <= 1'b0;
         codecShift_r <= 8'h00;
         rxShift_r    <= 8'h00;
         byteCnt_r    <= 3'h0;
      end
      else
      begin
         halfCnt_r <= codecTick ? '0 : CODEC_HALF_W'(halfCnt_r + 1'b1);
         if (codecTick)
            codecClk_r <= !codecClk_r;
         if (codecRise)
         begin
            bitIdx_r     <= 3'(bitIdx_r + 1'b1);
            codecSync_r  <= byteWrap;
            codecShift_r <= byteWrap ? nextByte : {codecShift_r[6:0], 1'b0};
         end
         if (codecFall)
            rxShift_r <= rxByte;
         if (byteDone)
            byteCnt_r <= 3'(byteCnt_r + 1'b1);
      end
   end

   // Codec register-side outputs.
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         codecRdData      <= 8'h00;
         codecRxEmptyFlag <= 1'b1;
         codecTxFullFlag  <= 1'b0;
         codecHalfFifoIrq <= 1'b0;
      end
      else
      begin
         codecRdData      <= rxHeadC;
         codecRxEmptyFlag <= !codecActive || !rxValidC;
         codecTxFullFlag  <= codecActive && !txReadyC;
         codecHalfFifoIrq <= codecIrqEnable && byteDone &&
                             (byteCnt_r == 3'(CODEC_IRQ_BYTES - 1));
      end
   end

   // Audio clock divider; the divisor sets the master clock to 256 fs.
   wire logic extEdge = extSync_r[1] && !extSync_r[2];
   wire logic srcTick = audioClockSource ? extEdge : 1'b1;
   wire logic divLast = (AUD_DIV_W'(divCnt_r + 1'b1) >= audioClockDivisor);
   wire logic mclkTick = audioRun && srcTick && divLast;
   wire logic [AUD_DIV_W-1:0] divCntNxt = !srcTick ? divCnt_r :
      divLast ? '0 : AUD_DIV_W'(divCnt_r + 1'b1);
   wire logic [1:0] phNxt = 2'(mclkPh_r + 1'b1);
   // Both selects are consulted; 64x runs only with the 64x select set and the 128x select clear.
   wire logic slow = bitclk64xSelect && !bitclk128xSelect;
   wire logic bRise = mclkTick && !bclkLevel(mclkPh_r, slow) && bclkLevel(phNxt, slow);
   wire logic bFall = mclkTick && bclkLevel(mclkPh_r, slow) && !bclkLevel(phNxt, slow);

   // Frame position decode.
   wire logic [6:0] frameLast = slow ? 7'(AUD_FRAME_64 - 1) : 7'(AUD_FRAME_128 - 1);
   wire logic [6:0] frameHalf = slow ? 7'(AUD_FRAME_64 / 2) : 7'(AUD_FRAME_128 / 2);
   wire logic [6:0] fbNxt = (frameBit_r >= frameLast) ? 7'h00 : 7'(frameBit_r + 1'b1);
   wire logic inLeftNxt  = (fbNxt < 7'(AUD_SAMPLE_W));
   wire logic inRightNxt = (fbNxt >= frameHalf) && (fbNxt < 7'(frameHalf + AUD_SAMPLE_W));
   wire logic inLeftNow  = (frameBit_r < 7'(AUD_SAMPLE_W));
   wire logic inRightNow = (frameBit_r >= frameHalf) &&
                           (frameBit_r < 7'(frameHalf + AUD_SAMPLE_W));
   wire logic frameStart = bFall && (fbNxt == 7'h00);
   wire logic popAud = frameStart && audioTxChanEnable && txValidA;
   wire logic underflowSet = frameStart && audioTxChanEnable && !txValidA;
   wire mcap_sample_t frameSample = !frameStart ? curSample_r :
      popAud ? txHeadA : '0;
   // Frame half widths are multiples of 16, so the low nibble is the bit offset.
   wire logic sdoutNxt = inLeftNxt  ? frameSample.left[4'hF - fbNxt[3:0]] :
                         inRightNxt ? frameSample.right[4'hF - fbNxt[3:0]] : 1'b0;
   wire logic rxLastBit = bRise && (frameBit_r == 7'(frameHalf + AUD_SAMPLE_W - 1));
   wire logic pushAud = rxLastBit && audioRxChanEnable;
   wire logic overflowSet = pushAud && !rxReadyA;
   wire mcap_sample_t rxWord = '{left: rxLeft_r, right: {rxRight_r[14:0], rxSync_r}};

   // Priming is possible as soon as the port is routed to audio.
   mcap_fifo #(.WIDTH($bits(mcap_sample_t)), .DEPTH(AUD_TX_FD)) audioTxFifo
   (
      .clock  (clock),
      .rst    (rst),
      .flush  (!audioRun),
      .wrValid(audioTxValid),
      .wrData (audioTxData),
      .wrReady(txReadyA),
      .rdReady(popAud),
      .rdValid(txValidA),
      .rdData (txHeadA)
   );

   mcap_fifo #(.WIDTH($bits(mcap_sample_t)), .DEPTH(AUD_RX_FD)) audioRxFifo
   (
      .clock  (clock),
      .rst    (rst),
      .flush  (!audioRun),
      .wrValid(pushAud),
      .wrData (rxWord),
      .wrReady(rxReadyA),
      .rdReady(audioRxPop),
      .rdValid(rxValidA),
      .rdData (rxHeadA)
   );

   // Audio frame engine.
   always_ff @(posedge clock)
   begin
      if (rst || !audioRun)
      begin
         divCnt_r    <= '0;
         mclkPh_r    <= 2'h0;
         mclk_r      <= 1'b0;
         bclk_r      <= 1'b0;
         frameBit_r  <= 7'(AUD_FRAME_128 - 1);
         wordClk_r   <= 1'b0;
         audio_serial_out_r     <= 1'b0;
         curSample_r <= '0;
         rxLeft_r    <= 16'h0000;
         rxRight_r   <= 16'h0000;
      end
      else
      begin
         divCnt_r <= divCntNxt;
         mclk_r   <= (divCntNxt < (audioClockDivisor >> 1)) ? 1'b0 : 1'b1;
         if (mclkTick)
         begin
            mclkPh_r <= phNxt;
            bclk_r   <= bclkLevel(phNxt, slow);
         end
         if (bFall)
         begin
            frameBit_r  <= fbNxt;
            wordClk_r   <= (fbNxt < frameHalf);
            audio_serial_out_r     <= sdoutNxt;
            curSample_r <= frameSample;
         end
         if (bRise && inLeftNow)
            rxLeft_r <= {rxLeft_r[14:0], rxSync_r};
         if (bRise && inRightNow)
            rxRight_r <= {rxRight_r[14:0], rxSync_r};
      end
   end

   // Audio status; a new event wins over a clear in the same cycle.
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         audioUnderflow <= AUD_UNDERFLOW_RST;
         audioOverflow  <= AUD_OVERFLOW_RST;
         audioTxReady   <= 1'b0;
         audioRxValid   <= 1'b0;
         audioRxData    <= '0;
      end
      else
      begin
         audioUnderflow <= (audioUnderflow && !underflowClear) || underflowSet;
         audioOverflow  <= (audioOverflow && !overflowClear) || overflowSet;
         audioTxReady   <= txReadyA;
         audioRxValid   <= rxValidA;
         audioRxData    <= rxHeadA;
      end
   end

   // Shared pin routing; in the serial slave case nothing is driven.
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         portClkPin    <= '0;
         portFramePin  <= '0;
         portTxDataPin <= '0;
         portAuxPin    <= '0;
      end
      else
      begin
         unique case (portMode)
            PORT_CODEC:
            begin
               portClkPin    <= '{value: codecClk_r, drive: 1'b1};
               portFramePin  <= '{value: codecSync_r, drive: 1'b1};
               portTxDataPin <= '{value: codecShift_r[7], drive: codecTransmitEnable};
               portAuxPin    <= '0;
            end
            PORT_AUDIO:
            begin
               portClkPin    <= '{value: bclk_r, drive: 1'b1};
               portFramePin  <= '{value: wordClk_r, drive: 1'b1};
               portTxDataPin <= '{value: audio_serial_out_r, drive: 1'b1};
               portAuxPin    <= '{value: mclk_r, drive: 1'b1};
            end
            default:
            begin
               portClkPin    <= '0;
               portFramePin  <= '0;
               portTxDataPin <= '0;
               portAuxPin    <= '0;
            end
         endcase
      end
   end

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (rst);

   sequence seq_eighth_byte;
      byteDone && codecIrqEnable && (byteCnt_r == 3'h7);
   endsequence

   a_codec_idle_quiet: assert property (!codecActive |=> !codecClk_r && halfCnt_r == '0)
      else $error("Codec timing runs with both enables clear");
   a_sync_on_msb: assert property (codecSync_r |-> bitIdx_r == 3'h0)
      else $error("Codec sync is high outside the first bit");
   a_sync_rise_edge: assert property ($rose(codecSync_r) |-> codecClk_r)
      else $error("Codec sync did not start on a rising bit clock");
   a_zero_fill: assert property (byteWrap && !txValidC |=> codecShift_r == 8'h00)
      else $error("Empty transmit FIFO did not send zero");
   a_tx_pin_off: assert property
      (portMode == PORT_CODEC && !codecTransmitEnable |=> !portTxDataPin.drive)
      else $error("Codec output driven while transmit is disabled");
   a_empty_when_off: assert property
      (!codecActive |=> codecRxEmptyFlag && !codecTxFullFlag)
      else $error("Idle codec FIFOs do not look empty");
   a_irq_eight_bytes: assert property (seq_eighth_byte |=> codecHalfFifoIrq ##1 !codecHalfFifoIrq)
      else $error("Codec interrupt missed after eight bytes");
   a_pad_zero: assert property (bFall && !inLeftNxt && !inRightNxt |=> !audio_serial_out_r)
      else $error("Audio pad bit is not zero");
   a_word_fall: assert property
      ($fell(wordClk_r) && $past(audioRun) && audioRun |-> frameBit_r == frameHalf)
      else $error("Word clock fell away from the right half start");
   a_status_sticky: assert property (audioUnderflow && !underflowClear |=> audioUnderflow)
      else $error("Underflow flag lost without a clear");

endmodule

// ---- tb/mcap_partner.sv ----
`timescale 1ns/10ps
module mcap_partner
   import mcap_pkg::*;
   (
   // Port pins
   input  wire logic         clock,
   input  wire logic         audioMode,
   input  wire mcap_pin_t    portClkPin,
   input  wire mcap_pin_t    portFramePin,
   input  wire mcap_pin_t    portTxDataPin,
   // Line into the port
   output logic              serialInPin = 1'b0,
   // Observed traffic
   output logic [7:0]        codecByte = 8'h00,
   output logic              codecByteDone = 1'b0,
   output logic [127:0]      audioFrame = '0,
   output logic              audioFrameDone = 1'b0
   );
   localparam logic [127:0] AUD_PAT = {16'hC3A5, 48'h0, 16'h0F1E, 48'h0};
   logic       clkPrev = 1'b0;
   logic       framePrev = 1'b0;
   logic [3:0] bitCnt = 4'h0;
   logic [7:0] sendSh = 8'h00;
   logic [7:0] nextVal = 8'h01;
   logic [6:0] aIdx = 7'h7F;
   wire        clkRise = portClkPin.value && !clkPrev;
   wire        clkFall = !portClkPin.value && clkPrev;
   wire        sync = portFramePin.value;
   // A released data line reads inverted, so it never passes for real data.
   wire        txBit = portTxDataPin.value ^ !portTxDataPin.drive;
   wire  [6:0] aNext = (sync && !framePrev) ? 7'h00 : aIdx + 7'h01;
   always @(posedge clock)
   begin
      clkPrev <= portClkPin.value;
      codecByteDone <= 1'b0;
      audioFrameDone <= 1'b0;
      if (audioMode && clkRise)
      begin
         // The word clock rise marks bit 0 of a frame.
         aIdx <= aNext;
         framePrev <= sync;
         audioFrame[7'h7F - aNext] <= txBit;
         audioFrameDone <= (aNext == 7'h7F);
         // Driven a whole bit ahead, so the synchroniser lag cannot smear it.
         serialInPin <= AUD_PAT[7'h7E - aNext];
      end
      else if (!audioMode && clkRise)
      begin
         // A new byte starts with its MSB inside the sync bit.
         serialInPin <= sync ? nextVal[7] : sendSh[7];
         sendSh <= sync ? {nextVal[6:0], 1'b0} : {sendSh[6:0], 1'b0};
         nextVal <= sync ? nextVal + 8'h13 : nextVal;
      end
      else if (!audioMode && clkFall)
      begin
         // Transmit bits are read mid-bit, MSB first.
         codecByte <= {codecByte[6:0], txBit};
         bitCnt <= sync ? 4'h1 : bitCnt + 4'h1;
         codecByteDone <= (bitCnt == 4'h7) && !sync;
      end
   end
endmodule

// ---- tb/muxed_codec_and_audio_port_tb.sv ----
`timescale 1ns/10ps
module muxed_codec_and_audio_port_tb;
   import mcap_pkg::*;
   localparam int H = 8;
   logic clock = 1'b0, rst = 1'b1, audioPortSelect = 1'b0, audioPortEnable = 1'b0;
   logic serialPortSelect = 1'b0, codecReceiveEnable = 1'b0, codecTransmitEnable = 1'b0;
   logic codecIrqEnable = 1'b0, codecWrValid = 1'b0, codecRdPop = 1'b0, serialInPin;
   logic bitclk64xSelect = 1'b0, bitclk128xSelect = 1'b0, audioTxChanEnable = 1'b0;
   logic audioRxChanEnable = 1'b0, underflowClear = 1'b0, overflowClear = 1'b0;
   logic audioTxValid = 1'b0, audioRxPop = 1'b0, codecByteDone, audioFrameDone;
   logic codecRxEmptyFlag, codecTxFullFlag, codecHalfFifoIrq, audioTxReady;
   logic audioRxValid, audioUnderflow, audioOverflow, audioClockSource = 1'b0;
   logic [7:0] codecWrData = 8'h00, audioClockDivisor = 8'h00, codecRdData, codecByte;
   logic [127:0] audioFrame;
   mcap_sample_t audioTxData = '0, audioRxData;
   mcap_pin_t portClkPin, portFramePin, portTxDataPin, portAuxPin;
   int errors = 0, checked = 0, cyc = 0;
   mcap_port #(.CODEC_HALF(H)) i_dut (.clock, .rst, .audioPortSelect, .audioPortEnable,
      .serialPortSelect, .codecReceiveEnable, .codecTransmitEnable, .codecIrqEnable,
      .codecWrValid, .codecWrData, .codecRdPop, .codecRdData, .codecRxEmptyFlag,
      .codecTxFullFlag, .codecHalfFifoIrq, .bitclk64xSelect, .bitclk128xSelect,
      .audioClockSource, .audioClockDivisor, .audioTxChanEnable, .audioRxChanEnable,
      .underflowClear, .overflowClear, .audioTxValid, .audioTxData, .audioTxReady,
      .audioRxPop, .audioRxData, .audioRxValid, .audioUnderflow, .audioOverflow,
      .extAudioClock(cyc[1]), .serialInPin, .portClkPin, .portFramePin, .portTxDataPin,
      .portAuxPin);
   mcap_partner i_partner (.clock, .audioMode(audioPortSelect && audioPortEnable),
      .portClkPin, .portFramePin, .portTxDataPin, .serialInPin, .codecByte,
      .codecByteDone, .audioFrame, .audioFrameDone);
   initial
   begin
      forever #5 clock = ~clock;
   end
   always @(posedge clock) cyc <= cyc + 1;
   task automatic complete_run;
      $display("checked %0d errors %0d", checked, errors);
      if (errors == 0 && checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic check(input string name, input logic [127:0] seen, input logic [127:0] exp);
      checked++;
      if (seen !== exp)
      begin
         errors++;
         $display("BAD %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic tick(input int n);
      repeat (n)
      begin
         @(posedge clock);
         #1;
      end
   endtask
   function automatic logic hit(input int sel);
      case (sel)
         0: return codecByteDone === 1'b1;
         1: return codecHalfFifoIrq === 1'b1;
         2: return audioFrameDone === 1'b1;
         3: return audioRxValid === 1'b1;
         4: return portAuxPin.value === 1'b1;
         5: return portAuxPin.value === 1'b0;
         6: return portClkPin.value === 1'b1;
         default: return portClkPin.value === 1'b0;
      endcase
   endfunction
   // Every wait is bounded; running out of time ends the run as a failure.
   task automatic waitFor(input int sel, input int lim, output int n);
      n = 0;
      do
      begin
         tick(1);
         n++;
      end while (!hit(sel) && n < lim);
      if (!hit(sel))
      begin
         errors++;
         $display("BAD wait%0d expected 1 seen 0", sel);
         complete_run;
      end
   endtask
   task automatic period(input int sel, output int p);
      int a;
      int b;
      waitFor(sel + 1, 40, a);
      waitFor(sel, 40, a);
      waitFor(sel + 1, 40, a);
      waitFor(sel, 40, b);
      p = a + b;
   endtask
   task automatic wr(input logic [7:0] b);
      @(posedge clock);
      codecWrValid <= 1'b1;
      codecWrData <= b;
      @(posedge clock);
      codecWrValid <= 1'b0;
   endtask
   initial
   begin
      int n;
      int t0;
      repeat (20) @(posedge clock);
      rst <= 1'b0;
      tick(2);
      check("rxEmpty", codecRxEmptyFlag, 1'b1);
      check("txFull", codecTxFullFlag, 1'b0);
      check("audFlags", {audioUnderflow, audioOverflow}, 2'b11);
      check("drives", {portClkPin.drive, portFramePin.drive, portTxDataPin.drive}, 3'h0);
      @(posedge clock);
      serialPortSelect <= 1'b1;
      tick(3 * H);
      check("idleClk", {portClkPin.value, codecHalfFifoIrq}, 2'b00);
      @(posedge clock);
      codecIrqEnable <= 1'b1;
      codecReceiveEnable <= 1'b1;
      t0 = cyc;
      for (int i = 0; i < 16; i++) wr(8'h10 + i[7:0]);
      tick(3);
      check("txFull16", codecTxFullFlag, 1'b1);
      check("txDrive", portTxDataPin.drive, 1'b0);
      waitFor(1, 80 * 2 * H, n);
      check("irqAt", (cyc - t0) inside {[8 * 16 * H - 8 : 8 * 16 * H + 8]}, 1'b1);
      @(posedge clock);
      codecTransmitEnable <= 1'b1;
      for (int k = 0; k < 4 && codecByte !== 8'h10; k++) waitFor(0, 20 * H, n);
      check("txFirst", codecByte, 8'h10);
      check("txDriveOn", {portTxDataPin.drive, codecRxEmptyFlag}, 2'b10);
      for (int i = 1; i < 17; i++)
      begin
         waitFor(0, 20 * H, n);
         check("txByte", codecByte, (i < 16) ? 8'h10 + i[7:0] : 8'h00);
      end
      for (int i = 0; i < 8; i++)
      begin
         check("rxByte", codecRdData, 8'h01 + 8'h13 * i[7:0]);
         @(posedge clock);
         codecRdPop <= 1'b1;
         @(posedge clock);
         codecRdPop <= 1'b0;
         tick(2);
      end
      @(posedge clock);
      codecReceiveEnable <= 1'b0;
      codecTransmitEnable <= 1'b0;
      tick(4);
      check("offFlags", {codecRxEmptyFlag, codecTxFullFlag}, 2'b10);
      @(posedge clock);
      serialPortSelect <= 1'b0;
      audioPortSelect <= 1'b1;
      audioPortEnable <= 1'b1;
      bitclk128xSelect <= 1'b1;
      audioClockDivisor <= 8'h04;
      @(posedge clock);
      underflowClear <= 1'b1;
      overflowClear <= 1'b1;
      audioTxValid <= 1'b1;
      audioTxData <= {16'h1234, 16'hABCD};
      @(posedge clock);
      underflowClear <= 1'b0;
      overflowClear <= 1'b0;
      audioTxValid <= 1'b0;
      tick(2);
      check("audClr", {audioUnderflow, audioOverflow, audioTxReady}, 3'b001);
      period(4, n);
      check("mclkPer", n, 4);
      period(6, n);
      check("bclk128", n, 8);
      waitFor(2, 1100, n);
      @(posedge clock);
      audioTxChanEnable <= 1'b1;
      audioRxChanEnable <= 1'b1;
      for (int k = 0; k < 3 && audioFrame[127:112] !== 16'h1234; k++) waitFor(2, 1100, n);
      check("frame", audioFrame, {16'h1234, 48'h0, 16'hABCD, 48'h0});
      waitFor(2, 1100, n);
      tick(2);
      check("underflow", {audioUnderflow, audioOverflow}, 2'b10);
      waitFor(3, 1100, n);
      check("rxSample", audioRxData, {16'hC3A5, 16'h0F1E});
      @(posedge clock);
      bitclk64xSelect <= 1'b1;
      bitclk128xSelect <= 1'b0;
      period(6, n);
      period(6, n);
      check("bclk64", n, 16);
      @(posedge clock);
      audioClockSource <= 1'b1;
      period(4, n);
      check("extMclk", n, 16);
      complete_run;
   end
endmodule
